// ---- rtl/tic_top.sv ----
`timescale 1ns/1ps
`include "tic_params.svh"

// Notes on behaviour
// [RULE1] Run enable at 0 stops the timer, at 1 runs it; readable and writable.
// [RULE2] Each timer event sets the event flag, held until software clears it.
// [RULE3] Writing 0 to the event flag clears it and arms it again.
// [RULE4] Writing 1 to the event flag changes nothing.
// [RULE5] Clearing the flag does not stop counting while run enable is 1.
// [RULE6] Level mode: clearing the flag releases the interrupt pin.
// [RULE7] Level mode: next 01h to 00h step sets flag again, pin low.
// [RULE8] Reading the flag returns 1 while an uncleared event stands.
// [RULE9] With interrupt enable 1, an event pulls the pin low.
// [RULE10] With interrupt enable 0 the pin is released and stays released.
// [RULE11] Level mode: enabling while the flag stands pulls the pin low at once.
// [RULE12] An event happens when the running counter steps from 01h to 00h.
// [RULE13] Mode select 0 is level mode, 1 is repeated mode.
// [RULE14] Repeated mode: pin low only for the auto release time per event.
// [RULE15] Interrupt pin is active low open drain, released when idle.

module tic_top #(
  parameter int HALF_CYC = `TIC_HALF_TICK_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        tirq_n_i,
  output logic             tirq_n_o,
  output logic             tirq_n_oe_n
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx[5:0], 2'b00};
  endfunction

  // Auto release length in half ticks of the 4096 Hz source
  function automatic logic [7:0] rtn_len(input tic_pkg::tic_src_e src,
                                         input logic [7:0] preset);
    case (src)
      tic_pkg::tic_src_4096:
        rtn_len = (preset == `TIC_CNT_LAST) ? `TIC_RTN_FAST_SHORT : `TIC_RTN_FAST;
      tic_pkg::tic_src_64:
        rtn_len = (preset == `TIC_CNT_LAST) ? `TIC_RTN_MID_SHORT : `TIC_RTN_LONG;
      default:
        rtn_len = `TIC_RTN_LONG;
    endcase
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic                run_r;
  tic_pkg::tic_src_e   src_r;
  logic [7:0]          preset_r;
  logic [7:0]          cnt_r;
  logic                flag_r;
  logic                irq_en_r;
  tic_pkg::tic_mode_e  mode_r;
  logic [7:0]          rtn_r;
  logic [1:0]          stat_r;
  logic [1:0]          mask_r;
  logic                pin_lvl_r;
  tic_pkg::tic_ticks_s ticks;

  tic_prescaler #(
    .HALF_CYC (HALF_CYC)
  ) u_pre (
    .pclk    (pclk),
    .presetn (presetn),
    .ticks   (ticks)
  );

  // ****************************************
  // APB decode
  // ****************************************
  tic_pkg::tic_apb_req_s req;
  assign req = '{addr: paddr, write: pwrite, wdata: pwdata};

  wire setup_w  = psel & ~penable;
  wire access_w = psel & penable & pready;
  wire hit_cs   = req.addr == byte_addr(`TIC_IDX_CTRL_STAT);
  wire hit_tc   = req.addr == byte_addr(`TIC_IDX_TIMER_CTRL);
  wire hit_pr   = req.addr == byte_addr(`TIC_IDX_PRESET);
  wire hit_is   = req.addr == byte_addr(`TIC_IDX_IRQ_STAT);
  wire hit_im   = req.addr == byte_addr(`TIC_IDX_IRQ_MASK);
  wire hit_any  = hit_cs | hit_tc | hit_pr | hit_is | hit_im;
  wire wr_w     = access_w & req.write & ~pslverr;
  wire wr_cs    = wr_w & hit_cs;
  wire wr_tc    = wr_w & hit_tc;
  wire wr_pr    = wr_w & hit_pr;
  wire wr_is    = wr_w & hit_is;
  wire wr_im    = wr_w & hit_im;
  wire clr_flag = wr_cs & ~req.wdata[`TIC_CS_FLAG]; // [RULE3] [RULE4]

  wire [7:0] rd_cs = 8'(
    ({7'h00, flag_r} << `TIC_CS_FLAG) |
    ({7'h00, irq_en_r} << `TIC_CS_IRQ_EN) |
    ({7'h00, mode_r == tic_pkg::tic_repeat} << `TIC_CS_REPEAT)); // [RULE8]
  wire [7:0] rd_tc = 8'(({7'h00, run_r} << `TIC_TC_RUN) |
    ({6'h00, src_r} << `TIC_TC_SRC_LSB)); // [RULE1]
  // Counter is shown while running; a mid-step read may need a second read
  wire [7:0] rd_pr = run_r ? cnt_r : preset_r;
  wire [7:0] rd_is = 8'({pin_lvl_r, 5'h00, stat_r});
  wire [7:0] rd_im = {6'h00, mask_r};
  wire [7:0] rd_val = hit_cs ? rd_cs : hit_tc ? rd_tc : hit_pr ? rd_pr :
                      hit_is ? rd_is : hit_im ? rd_im : 8'h00;

  // ****************************************
  // Countdown and event
  // ****************************************
  wire src_tick = (src_r == tic_pkg::tic_src_4096) ? ticks.t4096 :
                  (src_r == tic_pkg::tic_src_64)   ? ticks.t64 :
                  (src_r == tic_pkg::tic_src_sec)  ? ticks.t1 : ticks.t60;
  wire step_w   = run_r & src_tick; // [RULE1]
  wire evt_w    = step_w & (cnt_r == `TIC_CNT_LAST); // [RULE12] [RULE7]

  wire [7:0] cnt_nxt = !run_r ? preset_r :
                       evt_w ? preset_r :
                       (step_w && cnt_r != `TIC_CNT_ZERO) ? cnt_r - 8'h01 : cnt_r; // [RULE5]

  // ****************************************
  // Control bits and flag
  // ****************************************
  // An event in the clearing cycle wins so it is never lost
  wire flag_nxt = evt_w | (flag_r & ~clr_flag); // [RULE2] [RULE3] [RULE4]
  wire irq_en_nxt = wr_cs ? req.wdata[`TIC_CS_IRQ_EN] : irq_en_r;
  wire mode_bit   = wr_cs ? req.wdata[`TIC_CS_REPEAT] : (mode_r == tic_pkg::tic_repeat);
  tic_pkg::tic_mode_e mode_nxt;
  assign mode_nxt = mode_bit ? tic_pkg::tic_repeat : tic_pkg::tic_level; // [RULE13]
  wire run_nxt = wr_tc ? req.wdata[`TIC_TC_RUN] : run_r;
  tic_pkg::tic_src_e src_nxt;
  assign src_nxt = wr_tc ? tic_pkg::tic_src_e'(req.wdata[`TIC_TC_SRC_LSB +: 2]) : src_r;
  wire [7:0] preset_nxt = wr_pr ? req.wdata[7:0] : preset_r;

  // ****************************************
  // Interrupt pin
  // ****************************************
  // Repeated mode pulse; a new event restarts it, a flag clear does not cut it
  wire [7:0] rtn_nxt =
    (mode_nxt != tic_pkg::tic_repeat) ? `TIC_CNT_ZERO :
    (evt_w && irq_en_nxt) ? rtn_len(src_r, preset_r) :
    (ticks.half && rtn_r != `TIC_CNT_ZERO) ? rtn_r - 8'h01 : rtn_r; // [RULE14]
  wire rel_evt = ticks.half & (rtn_r == `TIC_RTN_FAST_SHORT) & ~(evt_w & irq_en_nxt);

  // Pin follows the next register values so it moves on the same edge
  wire drive_nxt = irq_en_nxt & ((mode_nxt == tic_pkg::tic_level) ? flag_nxt :
                                 (rtn_nxt != `TIC_CNT_ZERO)); // [RULE6] [RULE9] [RULE10] [RULE11]

  // ****************************************
  // Sticky status, set wins over write one to clear
  // ****************************************
  wire [1:0] evt_vec = {rel_evt, evt_w};
  wire [1:0] w1c     = wr_is ? req.wdata[1:0] : 2'b00;
  wire [1:0] stat_nxt = (stat_r & ~w1c) | evt_vec;
  wire [1:0] mask_nxt = wr_im ? req.wdata[1:0] : mask_r;

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r    <= 1'b0;
      src_r    <= tic_pkg::tic_src_4096;
      preset_r <= `TIC_RST_BYTE;
      cnt_r    <= `TIC_RST_BYTE;
      flag_r   <= 1'b0;
      irq_en_r <= 1'b0;
      mode_r   <= tic_pkg::tic_level;
      rtn_r    <= `TIC_RST_BYTE;
    end else begin
      run_r    <= run_nxt;
      src_r    <= src_nxt;
      preset_r <= preset_nxt;
      cnt_r    <= cnt_nxt;
      flag_r   <= flag_nxt;
      irq_en_r <= irq_en_nxt;
      mode_r   <= mode_nxt;
      rtn_r    <= rtn_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r      <= 2'b00;
      mask_r      <= 2'b00;
      irq         <= 1'b0;
      pin_lvl_r   <= 1'b1;
      tirq_n_o    <= 1'b0;
      tirq_n_oe_n <= 1'b1;
    end else begin
      stat_r      <= stat_nxt;
      mask_r      <= mask_nxt;
      irq         <= |(stat_nxt & mask_nxt);
      pin_lvl_r   <= tirq_n_i;
      tirq_n_o    <= 1'b0; // [RULE15]
      tirq_n_oe_n <= ~drive_nxt; // [RULE15]
    end
  end

  // Zero wait after setup: read data is taken in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `TIC_RST_WORD;
    end else begin
      pready  <= setup_w;
      pslverr <= setup_w & (~hit_any | (paddr[1:0] != 2'b00));
      if (setup_w) prdata <= {24'h000000, rd_val};
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_stop_no_event; // [RULE1]
    @(posedge pclk) disable iff (!presetn)
      !run_r |-> !evt_w ##1 (cnt_r == $past(preset_r));
  endproperty
  a_stop_no_event: assert property (p_stop_no_event) // [RULE1]
    else $error("event while stopped");

  property p_event_sets_flag; // [RULE2]
    @(posedge pclk) disable iff (!presetn)
      evt_w |=> flag_r;
  endproperty
  a_event_sets_flag: assert property (p_event_sets_flag) // [RULE2]
    else $error("flag not set");

  property p_flag_holds; // [RULE8]
    @(posedge pclk) disable iff (!presetn)
      (flag_r && !clr_flag) |=> flag_r;
  endproperty
  a_flag_holds: assert property (p_flag_holds) // [RULE8]
    else $error("flag lost");

  property p_clear_flag; // [RULE3]
    @(posedge pclk) disable iff (!presetn)
      (clr_flag && !evt_w) |=> !flag_r;
  endproperty
  a_clear_flag: assert property (p_clear_flag) // [RULE3]
    else $error("flag not cleared");

  property p_write_one; // [RULE4]
    @(posedge pclk) disable iff (!presetn)
      (wr_cs && req.wdata[`TIC_CS_FLAG] && !evt_w) |=> flag_r == $past(flag_r);
  endproperty
  a_write_one: assert property (p_write_one) // [RULE4]
    else $error("write one changed flag");

  property p_clear_keeps_run; // [RULE5]
    @(posedge pclk) disable iff (!presetn)
      (clr_flag && run_r && !wr_tc) |=> run_r;
  endproperty
  a_clear_keeps_run: assert property (p_clear_keeps_run) // [RULE5]
    else $error("clear stopped timer");

  property p_level_pin; // [RULE6]
    @(posedge pclk) disable iff (!presetn)
      (mode_r == tic_pkg::tic_level) |-> (tirq_n_oe_n == !(flag_r && irq_en_r));
  endproperty
  a_level_pin: assert property (p_level_pin) // [RULE6]
    else $error("level pin mismatch");

  property p_event_drives; // [RULE9]
    @(posedge pclk) disable iff (!presetn)
      (evt_w && irq_en_r && !wr_cs) |=> !tirq_n_oe_n && flag_r;
  endproperty
  a_event_drives: assert property (p_event_drives) // [RULE9]
    else $error("event did not drive pin");

  property p_disabled_released; // [RULE10]
    @(posedge pclk) disable iff (!presetn)
      !irq_en_r |-> tirq_n_oe_n;
  endproperty
  a_disabled_released: assert property (p_disabled_released) // [RULE10]
    else $error("pin driven");

  property p_enable_rise; // [RULE11]
    @(posedge pclk) disable iff (!presetn)
      ($rose(irq_en_r) && flag_r && mode_r == tic_pkg::tic_level) |-> !tirq_n_oe_n;
  endproperty
  a_enable_rise: assert property (p_enable_rise) // [RULE11]
    else $error("enable rise not immediate");

  property p_event_at_one; // [RULE12]
    @(posedge pclk) disable iff (!presetn)
      (step_w && cnt_r == `TIC_CNT_LAST) |-> evt_w ##1 (cnt_r == $past(preset_r));
  endproperty
  a_event_at_one: assert property (p_event_at_one) // [RULE12]
    else $error("no event at 01h");

  property p_repeat_pin; // [RULE14]
    @(posedge pclk) disable iff (!presetn)
      (mode_r == tic_pkg::tic_repeat) |-> (tirq_n_oe_n == !(irq_en_r && rtn_r != 8'h00));
  endproperty
  a_repeat_pin: assert property (p_repeat_pin) // [RULE14]
    else $error("repeat pin mismatch");

  property p_pin_low_only; // [RULE15]
    @(posedge pclk) disable iff (!presetn)
      !tirq_n_o;
  endproperty
  a_pin_low_only: assert property (p_pin_low_only) // [RULE15]
    else $error("pin driven high");

  property p_mode_select; // [RULE13]
    @(posedge pclk) disable iff (!presetn)
      wr_cs |=> (mode_r == tic_pkg::tic_repeat) == $past(req.wdata[`TIC_CS_REPEAT]);
  endproperty
  a_mode_select: assert property (p_mode_select) // [RULE13]
    else $error("mode select not applied");

  property p_level_rearm; // [RULE7]
    @(posedge pclk) disable iff (!presetn)
      (evt_w && !flag_r && irq_en_r && mode_r == tic_pkg::tic_level && !wr_cs) |=>
        (flag_r && !tirq_n_oe_n);
  endproperty
  a_level_rearm: assert property (p_level_rearm) // [RULE7]
    else $error("cleared flag not set again");

  property p_auto_release; // [RULE14]
    @(posedge pclk) disable iff (!presetn)
      (mode_r == tic_pkg::tic_repeat && !wr_cs && !evt_w && ticks.half &&
       rtn_r == `TIC_RTN_FAST_SHORT) |=> tirq_n_oe_n;
  endproperty
  a_auto_release: assert property (p_auto_release) // [RULE14]
    else $error("pulse did not end by itself");

  property p_read_flag; // [RULE8]
    @(posedge pclk) disable iff (!presetn)
      (setup_w && hit_cs) |=> (prdata[`TIC_CS_FLAG] == $past(flag_r));
  endproperty
  a_read_flag: assert property (p_read_flag) // [RULE8]
    else $error("flag read back wrong");

  property p_run_write; // [RULE1]
    @(posedge pclk) disable iff (!presetn)
      wr_tc |=> (run_r == $past(req.wdata[`TIC_TC_RUN]));
  endproperty
  a_run_write: assert property (p_run_write) // [RULE1]
    else $error("run enable not written");

endmodule

// ---- common/tic_params.svh ----
`ifndef TIC_PARAMS_SVH
`define TIC_PARAMS_SVH

// ****************************************
// Clock and timing
// ****************************************
`define TIC_CLK_PERIOD_NS  100
`define TIC_HALF_TICK_NS   122070
`define TIC_HALF_TICK_CYC  (`TIC_HALF_TICK_NS / `TIC_CLK_PERIOD_NS)
`define TIC_SUB_64_LAST    7'h7F
`define TIC_SUB_SEC_LAST   13'h1FFF
`define TIC_MIN_LAST       6'h3B

// ****************************************
// Register indices, byte address is index times four
// ****************************************
`define TIC_IDX_CTRL_STAT  8'h01
`define TIC_IDX_TIMER_CTRL 8'h0E
`define TIC_IDX_PRESET     8'h0F
`define TIC_IDX_IRQ_STAT   8'h10
`define TIC_IDX_IRQ_MASK   8'h11

// ****************************************
// Field positions
// ****************************************
`define TIC_CS_IRQ_EN      0
`define TIC_CS_FLAG        2
`define TIC_CS_REPEAT      4
`define TIC_TC_RUN         7
`define TIC_TC_SRC_LSB     0
`define TIC_IS_TIMER       0
`define TIC_IS_RELEASE     1
`define TIC_IS_PIN         7

// ****************************************
// Reset values and counts
// ****************************************
`define TIC_RST_BYTE       8'h00
`define TIC_RST_WORD       32'h0000_0000
`define TIC_CNT_LAST       8'h01
`define TIC_CNT_ZERO       8'h00
`define TIC_RTN_FAST_SHORT 8'h01
`define TIC_RTN_FAST       8'h02
`define TIC_RTN_MID_SHORT  8'h40
`define TIC_RTN_LONG       8'h80

`endif

// ---- common/tic_pkg.sv ----
package tic_pkg;

  typedef enum logic {
    tic_level  = 1'b0,
    tic_repeat = 1'b1
  } tic_mode_e;

  typedef enum logic [1:0] {
    tic_src_4096 = 2'b00,
    tic_src_64   = 2'b01,
    tic_src_sec  = 2'b10,
    tic_src_min  = 2'b11
  } tic_src_e;

  typedef struct packed {
    logic half;
    logic t4096;
    logic t64;
    logic t1;
    logic t60;
  } tic_ticks_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic        write;
    logic [31:0] wdata;
  } tic_apb_req_s;

endpackage

// ---- rtl/tic_prescaler.sv ----
`timescale 1ns/1ps
`include "tic_params.svh"

module tic_prescaler #(
  parameter int HALF_CYC = `TIC_HALF_TICK_CYC
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  output tic_pkg::tic_ticks_s     ticks
);

  // ****************************************
  // Elaboration check
  // ****************************************
  generate
    if (HALF_CYC < 1 || HALF_CYC > 65535) begin : g_bad
      $error("tic_prescaler: HALF_CYC out of range");
    end
  endgenerate

  logic [15:0] pre_r;
  logic [12:0] sub_r;
  logic [5:0]  min_r;

  wire half_w = (pre_r == 16'(HALF_CYC - 1));
  wire sec_w  = half_w & (sub_r == `TIC_SUB_SEC_LAST);

  // Free running so that the seconds and minutes sources share one time base
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 16'h0000;
      sub_r <= 13'h0000;
      min_r <= 6'h00;
    end else begin
      pre_r <= half_w ? 16'h0000 : pre_r + 16'h0001;
      if (half_w) sub_r <= sub_r + 13'h0001;
      if (sec_w) min_r <= (min_r == `TIC_MIN_LAST) ? 6'h00 : min_r + 6'h01;
    end
  end

  assign ticks.half  = half_w;
  assign ticks.t4096 = half_w & sub_r[0];
  assign ticks.t64   = half_w & (sub_r[6:0] == `TIC_SUB_64_LAST);
  assign ticks.t1    = sec_w;
  assign ticks.t60   = sec_w & (min_r == `TIC_MIN_LAST);

endmodule

// ---- test/tic_host_model.sv ----
`timescale 1ns/1ps

// ****************************************
// Host side of the open-drain interrupt pin
// ****************************************
module tic_host_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic tirq_n_o,
  input  wire logic tirq_n_oe_n,
  output logic      pin_level,
  output int        low_events
);
  logic pin_d_r;

  // Pull-up on the board: a released pin reads high, never the last driven value
  assign pin_level = tirq_n_oe_n ? 1'b1 : tirq_n_o;

  // Host counts assertions of the line to see how often it was interrupted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_d_r    <= 1'b1;
      low_events <= 0;
    end else begin
      pin_d_r <= pin_level;
      if (pin_d_r && !pin_level) begin
        low_events <= low_events + 1;
      end
    end
  end
endmodule

// ---- test/tb_timer_interrupt_control.sv ----
`timescale 1ns/1ps

module tb_timer_interrupt_control;
  localparam int HC = 2;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} tic_row_s;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        tirq_n_o, tirq_n_oe_n, pin;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        err;
  int          failures, checked, n, lows;
  tic_row_s    rows[13];

  tic_top #(.HALF_CYC(HC)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .tirq_n_i(pin), .tirq_n_o(tirq_n_o), .tirq_n_oe_n(tirq_n_oe_n)
  );

  tic_host_model host (
    .pclk(pclk), .presetn(presetn), .tirq_n_o(tirq_n_o), .tirq_n_oe_n(tirq_n_oe_n),
    .pin_level(pin), .low_events(lows)
  );

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic wrap_up();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      failures++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask

  // Bounded wait at the falling edge so the registered pin has settled
  task automatic wait_pin(input logic lvl, input int bound);
    int k;
    for (k = 0; k < bound && pin !== lvl; k++) @(negedge pclk);
    if (pin !== lvl) begin
      failures++;
      wrap_up();
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; failures = 0; checked = 0;
    rows = '{
      '{1'b0, 8'h04, 32'h0, 32'h00, 1'b0}, '{1'b0, 8'h38, 32'h0, 32'h00, 1'b0},
      '{1'b0, 8'h3C, 32'h0, 32'h00, 1'b0}, '{1'b0, 8'h40, 32'h0, 32'h80, 1'b0},
      '{1'b0, 8'h44, 32'h0, 32'h00, 1'b0}, '{1'b1, 8'h38, 32'h3, 32'h00, 1'b0},
      '{1'b0, 8'h38, 32'h0, 32'h03, 1'b0}, '{1'b1, 8'h04, 32'h15, 32'h00, 1'b0},
      '{1'b0, 8'h04, 32'h0, 32'h11, 1'b0}, '{1'b1, 8'h04, 32'h1, 32'h00, 1'b0},
      '{1'b1, 8'h38, 32'h0, 32'h00, 1'b0}, '{1'b0, 8'hFC, 32'h0, 32'h00, 1'b1},
      '{1'b1, 8'h05, 32'h1, 32'h00, 1'b1}};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    chk("pin after reset", {31'h0, tirq_n_oe_n}, 32'h1);
    // Reset values, read back of control bits, flag write of one ignored, unmapped
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("row rdata", rd, rows[i].x);
      chk("row pslverr", {31'h0, err}, {31'h0, rows[i].e});
    end
    // Level mode: preset 2, fastest source, interrupt enabled
    apb(1'b1, 8'h3C, 32'h02);
    apb(1'b1, 8'h44, 32'h01);
    apb(1'b1, 8'h38, 32'h80);
    wait_pin(1'b0, 500);
    rdchk("flag set", 8'h04, 32'h05);
    repeat (40) @(negedge pclk);
    chk("pin held", {31'h0, pin}, 32'h0);
    apb(1'b1, 8'h04, 32'h05);
    rdchk("flag kept", 8'h04, 32'h05);
    apb(1'b1, 8'h04, 32'h04);
    wait_pin(1'b1, 3);
    rdchk("flag stands", 8'h04, 32'h04);
    apb(1'b1, 8'h04, 32'h05);
    wait_pin(1'b0, 3);
    apb(1'b1, 8'h04, 32'h01);
    wait_pin(1'b1, 3);
    rdchk("flag cleared", 8'h04, 32'h01);
    wait_pin(1'b0, 500);
    rdchk("flag again", 8'h04, 32'h05);
    // Stopped timer keeps the flag but makes no further event
    apb(1'b1, 8'h38, 32'h00);
    rdchk("flag after stop", 8'h04, 32'h05);
    apb(1'b1, 8'h04, 32'h01);
    repeat (100) @(negedge pclk);
    chk("no event stopped", {31'h0, pin}, 32'h1);
    rdchk("flag idle", 8'h04, 32'h01);
    // Status interrupt: raise, mask, clear
    @(negedge pclk);
    chk("irq raised", {31'h0, irq}, 32'h1);
    apb(1'b1, 8'h44, 32'h00);
    repeat (2) @(negedge pclk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, 8'h44, 32'h01);
    repeat (2) @(negedge pclk);
    chk("irq unmasked", {31'h0, irq}, 32'h1);
    apb(1'b1, 8'h40, 32'h03);
    repeat (2) @(negedge pclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    // Repeated mode, preset 1: pulse lasts one half tick and returns by itself
    apb(1'b1, 8'h3C, 32'h01);
    apb(1'b1, 8'h04, 32'h11);
    apb(1'b1, 8'h38, 32'h80);
    wait_pin(1'b0, 500);
    n = 0;
    while (pin === 1'b0 && n < 50) begin
      @(negedge pclk);
      n++;
    end
    chk("pulse length", n, HC);
    n = lows;
    wait_pin(1'b0, 500);
    // The host counts a fall one clock after it shows on the pin
    @(negedge pclk);
    chk("second pulse", lows, n + 1);
    apb(1'b1, 8'h38, 32'h00);
    // Mid-run reset while the last pulse and the status interrupt still stand
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    chk("pin in reset", {31'h0, tirq_n_oe_n}, 32'h1);
    chk("irq in reset", {31'h0, irq}, 32'h0);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("ctrl after reset", 8'h04, 32'h00);
    rdchk("run after reset", 8'h38, 32'h00);
    rdchk("status after reset", 8'h40, 32'h80);
    wrap_up();
  end
endmodule
